// file: common/fwos_if.sv
`timescale 1ns/1ps
interface fwos_if;
  logic        wr_en;
  logic        rd_en;
  logic        word_access;
  logic        indirect;
  logic        from_internal_flash;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rvalid;
  logic        busy;
  modport dev
  (
    input  wr_en, rd_en, word_access, indirect, from_internal_flash, addr, wdata,
    output rdata, rvalid, busy
  );
  modport host
  (
    output wr_en, rd_en, word_access, indirect, from_internal_flash, addr, wdata,
    input  rdata, rvalid, busy
  );
endinterface

// file: common/fwos_pkg.sv
package fwos_pkg;
  localparam logic [3:0]  OFS_CONTROL0_UPPER     = 4'h0;
  localparam logic [3:0]  OFS_ERASE_SELECT_LOWER = 4'h1;
  localparam logic [3:0]  OFS_ERASE_SELECT_UPPER = 4'h2;
  localparam logic [3:0]  OFS_TARGET_ADDRESS_LOW = 4'h3;
  localparam logic [3:0]  OFS_TARGET_ADDRESS_HIGH = 4'h4;
  localparam logic [3:0]  OFS_DATA0_LOW          = 4'h5;
  localparam logic [3:0]  OFS_DATA0_HIGH         = 4'h6;
  localparam logic [3:0]  OFS_DATA1_LOW          = 4'h7;
  localparam logic [3:0]  OFS_DATA1_HIGH         = 4'h8;
  localparam logic [3:0]  OFS_FLASH_ERROR_REG    = 4'h9;
  localparam logic [3:0]  OFS_TEMP_UNPROTECT_REG = 4'hA;
  localparam logic [3:0]  OFS_NV_ACCESS_PROTECT  = 4'hB;
  localparam logic [3:0]  OFS_STATUS             = 4'hC;
  localparam int          BIT_START              = 15;
  localparam int          BIT_SUSPEND            = 14;
  localparam int          BIT_WPG                = 13;
  localparam int          BIT_DOUBLE_WORD_PROGRAM_SELECT               = 12;
  localparam int          BIT_SER                = 11;
  localparam int          BIT_SPR                = 8;
  localparam int          BIT_RESUME_ERR         = 0;
  localparam int          BIT_TEMP_UNPROTECT     = 0;
  localparam int          BIT_ADDRESS_TWO        = 2;
  localparam logic [15:0] SELECT_MASK            = 16'h3900;
  localparam logic [15:0] NV_ADDR_HIGH           = 16'h0008;
  localparam logic [15:0] NV_ACCESS_LOW          = 16'hDFB8;
  localparam logic [15:0] NV_PROTECT1_LOW        = 16'hDFBC;
  localparam logic [15:0] RST_NV                 = 16'hFFFF;
  localparam logic [15:0] RST_ZERO               = 16'h0000;
  localparam int          CLK_PERIOD_NS          = 10;
  localparam int          PROG_TIME_NS           = 1000;
  localparam int          ERASE_TIME_NS          = 20000;
  localparam int          PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_SUSPEND_REQUEST = 2'b11
  } fwos_state_t;
endpackage

// file: hw/fwos_device.sv
`timescale 1ns/1ps
module fwos_device
  import fwos_pkg::*;
#(
  parameter int PROG_CNT  = PROG_CYCLES,
  parameter int ERASE_CNT = ERASE_CYCLES
)
(
  input  wire logic  clk,
  input  wire logic  reset_n,
  fwos_if.dev        bus,
  output logic        arr_wr_valid,
  output logic [23:0] arr_addr,
  output logic [63:0] arr_data,
  output logic        arr_dword,
  output logic        arr_erase_valid,
  output logic [4:0]  arr_erase_sector,
  output logic        prot_access_on,
  output logic        prot_debug_on
);
  localparam int CW = $clog2((PROG_CNT > ERASE_CNT ? PROG_CNT : ERASE_CNT) + 1);
  if (PROG_CNT < 1 || ERASE_CNT < 1)
  begin : g_cnt_check
    $error("cycle counts must be at least one");
  end

  fwos_state_t st_r;
  logic [15:0] ctl_r, esl_r, esu_r, al_r, ah_r, d0l_r, d0h_r, d1l_r, d1h_r;
  logic [15:0] op_r, saved_r, nv_acc_r, nv_dis_r, nv_ren_r;
  logic        res_err_r, temp_unprotect_bit_r, held_r;
  logic [CW-1:0] tmr_r;
  logic [31:0] esel;
  logic [15:0] wd, sel_w, cur_sel;
  logic        acc_ok, prot_on, perm_off, reg_wr, wc, start_req, go_new, resume;
  logic        resume_ok, nest, abort, suspend_request_req, tmr_end, prog_done, sec_done, erase_done;
  logic [4:0]  low_idx;

  assign wd = bus.wdata;
  assign esel = {esu_r, esl_r};
  assign acc_ok = bus.wr_en & bus.word_access & bus.indirect;
  assign perm_off = $countones(~nv_dis_r) > $countones(~nv_ren_r);
  assign prot_on = ~nv_acc_r[0] & ~temp_unprotect_bit_r & ~perm_off;
  assign reg_wr = acc_ok & (~prot_on | bus.from_internal_flash);
  assign wc = reg_wr & (bus.addr == OFS_CONTROL0_UPPER);
  // a start write only adds bits, so 0x8000 keeps the selection
  assign cur_sel = (ctl_r | wd) & SELECT_MASK;
  assign sel_w = wd & SELECT_MASK;
  assign start_req = wc & wd[BIT_START] & ~wd[BIT_SUSPEND];
  assign go_new = start_req & (st_r == ST_IDLE) & (|cur_sel);
  assign resume = start_req & (st_r == ST_SUSPEND_REQUEST);
  assign resume_ok = resume & (cur_sel == saved_r);
  assign nest = resume & ~held_r & saved_r[BIT_SER] & ~cur_sel[BIT_SER]
              & (cur_sel[BIT_WPG] ^ cur_sel[BIT_DOUBLE_WORD_PROGRAM_SELECT]) & ~cur_sel[BIT_SPR];
  assign abort = resume & ~resume_ok & ~nest;
  // a suspend in the finishing cycle is dropped, the operation completes
  assign suspend_request_req = wc & wd[BIT_SUSPEND] & (st_r == ST_BUSY) & ~held_r & ~op_r[BIT_SPR]
                  & ~tmr_end;
  assign tmr_end = (st_r == ST_BUSY) & (tmr_r == '0);
  assign prog_done = tmr_end & ~op_r[BIT_SER];
  assign sec_done = tmr_end & op_r[BIT_SER];
  assign erase_done = sec_done & ((esel & (esel - 32'h1)) == 32'h0);

  always_comb
  begin
    low_idx = 5'h0;
    for (int i = 31; i >= 0; i--)
      if (esel[i])
        low_idx = 5'(i);
  end

  // operation state
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_r    <= ST_IDLE;
      op_r    <= RST_ZERO;
      saved_r <= RST_ZERO;
      held_r  <= 1'b0;
    end
    else if (go_new || resume_ok)
    begin
      st_r <= ST_BUSY;
      op_r <= cur_sel;
    end
    else if (nest)
    begin
      st_r   <= ST_BUSY;
      op_r   <= cur_sel;
      held_r <= 1'b1;
    end
    else if (abort)
      st_r <= ST_IDLE;
    else if (suspend_request_req)
    begin
      st_r    <= ST_SUSPEND_REQUEST;
      saved_r <= op_r;
    end
    else if (prog_done || erase_done)
    begin
      st_r   <= held_r ? ST_SUSPEND_REQUEST : ST_IDLE;
      op_r   <= held_r ? saved_r : RST_ZERO;
      held_r <= 1'b0;
    end
  end

  // cycle timer; an erase resumed after a nested program restarts its sector
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      tmr_r <= '0;
    else if (go_new || nest)
      tmr_r <= cur_sel[BIT_SER] ? CW'(ERASE_CNT - 1) : CW'(PROG_CNT - 1);
    else if ((sec_done && !erase_done) || (prog_done && held_r))
      tmr_r <= CW'(ERASE_CNT - 1);
    else if (st_r == ST_BUSY && tmr_r != '0)
      tmr_r <= tmr_r - CW'(1);
  end

  // control register zero upper
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      ctl_r <= RST_ZERO;
    else if (prog_done || erase_done || abort)
      ctl_r <= held_r ? (ctl_r & ~16'h8000) : RST_ZERO;
    else if (go_new || resume_ok || nest)
      ctl_r <= cur_sel | 16'h8000;
    else if (wc && !wd[BIT_START])
      ctl_r <= wd & (SELECT_MASK | 16'h4000);
  end

  // erase selection, cleared sector by sector
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      esl_r <= RST_ZERO;
      esu_r <= RST_ZERO;
    end
    else if (sec_done)
    begin
      esl_r <= esl_r & (esl_r - 16'h1 | (esl_r == RST_ZERO ? 16'hFFFF : 16'h0));
      esu_r <= (esl_r == RST_ZERO) ? (esu_r & (esu_r - 16'h1)) : esu_r;
    end
    else if (reg_wr && st_r != ST_BUSY && bus.addr == OFS_ERASE_SELECT_LOWER)
      esl_r <= wd;
    else if (reg_wr && st_r != ST_BUSY && bus.addr == OFS_ERASE_SELECT_UPPER)
      esu_r <= wd;
  end

  // address and data registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      al_r  <= RST_ZERO;
      ah_r  <= RST_ZERO;
      d0l_r <= RST_ZERO;
      d0h_r <= RST_ZERO;
      d1l_r <= RST_ZERO;
      d1h_r <= RST_ZERO;
    end
    else if (reg_wr && st_r != ST_BUSY)
    begin
      case (bus.addr)
        OFS_TARGET_ADDRESS_LOW:  al_r  <= wd;
        OFS_TARGET_ADDRESS_HIGH: ah_r  <= wd;
        OFS_DATA0_LOW:           d0l_r <= wd;
        OFS_DATA0_HIGH:          d0h_r <= wd;
        OFS_DATA1_LOW:           d1l_r <= wd;
        OFS_DATA1_HIGH:          d1h_r <= wd;
        default:                 al_r  <= al_r;
      endcase
    end
  end

  // error flag; the abort wins over a clearing write
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      res_err_r <= 1'b0;
    else if (abort)
      res_err_r <= 1'b1;
    else if (reg_wr && bus.addr == OFS_FLASH_ERROR_REG && !wd[BIT_RESUME_ERR])
      res_err_r <= 1'b0;
  end

  // temporary unprotect, only from internal flash fetches
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      temp_unprotect_bit_r <= 1'b0;
    else if (acc_ok && bus.from_internal_flash && bus.addr == OFS_TEMP_UNPROTECT_REG)
      temp_unprotect_bit_r <= wd[BIT_TEMP_UNPROTECT];
  end

  // nonvolatile protection; programming only clears bits
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      nv_acc_r <= RST_NV;
      nv_dis_r <= RST_NV;
      nv_ren_r <= RST_NV;
    end
    else if (prog_done && op_r[BIT_SPR] && ah_r == NV_ADDR_HIGH)
    begin
      if (al_r == NV_ACCESS_LOW)
        nv_acc_r <= nv_acc_r & d0l_r;
      if (al_r == NV_PROTECT1_LOW)
      begin
        nv_dis_r <= nv_dis_r & d0l_r;
        nv_ren_r <= nv_ren_r & (d0h_r | nv_dis_r);
      end
    end
  end

  // array writes and erase pulses
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      arr_wr_valid     <= 1'b0;
      arr_addr         <= 24'h0;
      arr_data         <= 64'h0;
      arr_dword        <= 1'b0;
      arr_erase_valid  <= 1'b0;
      arr_erase_sector <= 5'h0;
    end
    else
    begin
      arr_wr_valid    <= prog_done & ~op_r[BIT_SPR];
      arr_erase_valid <= sec_done;
      if (sec_done)
        arr_erase_sector <= low_idx;
      if (prog_done && !op_r[BIT_SPR])
      begin
        arr_dword <= op_r[BIT_DOUBLE_WORD_PROGRAM_SELECT];
        arr_addr  <= {ah_r[7:0], al_r[15:3], al_r[2] & ~op_r[BIT_DOUBLE_WORD_PROGRAM_SELECT], al_r[1:0]};
        arr_data  <= op_r[BIT_DOUBLE_WORD_PROGRAM_SELECT] ? {d1h_r, d1l_r, d0h_r, d0l_r}
                                    : {32'h0, d0h_r, d0l_r};
      end
    end
  end

  // register read port and status outputs
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      bus.rdata      <= RST_ZERO;
      bus.rvalid     <= 1'b0;
      bus.busy       <= 1'b0;
      prot_access_on <= 1'b0;
      prot_debug_on  <= 1'b0;
    end
    else
    begin
      bus.rvalid     <= bus.rd_en;
      bus.busy       <= (st_r == ST_BUSY);
      prot_access_on <= prot_on;
      prot_debug_on  <= ~nv_acc_r[1] & ~perm_off;
      case (bus.addr)
        OFS_CONTROL0_UPPER:      bus.rdata <= held_r ? (ctl_r & ~16'h4800) : ctl_r;
        OFS_ERASE_SELECT_LOWER:  bus.rdata <= esl_r;
        OFS_ERASE_SELECT_UPPER:  bus.rdata <= esu_r;
        OFS_TARGET_ADDRESS_LOW:  bus.rdata <= al_r;
        OFS_TARGET_ADDRESS_HIGH: bus.rdata <= ah_r;
        OFS_DATA0_LOW:           bus.rdata <= d0l_r;
        OFS_DATA0_HIGH:          bus.rdata <= d0h_r;
        OFS_DATA1_LOW:           bus.rdata <= d1l_r;
        OFS_DATA1_HIGH:          bus.rdata <= d1h_r;
        OFS_FLASH_ERROR_REG:     bus.rdata <= {15'h0, res_err_r};
        OFS_TEMP_UNPROTECT_REG:  bus.rdata <= {15'h0, temp_unprotect_bit_r};
        OFS_NV_ACCESS_PROTECT:   bus.rdata <= nv_acc_r;
        OFS_STATUS:              bus.rdata <= {13'h0, held_r, st_r};
        default:                 bus.rdata <= RST_ZERO;
      endcase
    end
  end
endmodule

// file: hw/fwos_host.sv
`timescale 1ns/1ps
module fwos_host
  import fwos_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  fwos_if.host             bus,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [3:0]  cmd_addr,
  input  wire logic [15:0] cmd_data,
  input  wire logic        run_from_internal_flash,
  output logic             cmd_ready,
  output logic             cmd_refused,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data
);
  logic suspend_request_sh_r, wait_r, take, is_temp_unprotect_bit, refuse;

  assign take = cmd_valid & cmd_ready;
  assign is_temp_unprotect_bit = cmd_addr == OFS_TEMP_UNPROTECT_REG;
  // flash registers from RAM only; unprotect bit from flash only
  assign refuse = cmd_write & ((run_from_internal_flash & ~is_temp_unprotect_bit)
                | (~run_from_internal_flash & is_temp_unprotect_bit)
                | (cmd_addr == OFS_CONTROL0_UPPER & cmd_data[BIT_START]
                   & (suspend_request_sh_r | cmd_data[BIT_SUSPEND])));

  // shadow of the suspend bit last written
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      suspend_request_sh_r <= 1'b0;
    else if (take && !refuse && cmd_write && cmd_addr == OFS_CONTROL0_UPPER && !cmd_data[BIT_START])
      suspend_request_sh_r <= cmd_data[BIT_SUSPEND];
  end

  // one word access per command, always through a pointer
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      bus.wr_en       <= 1'b0;
      bus.rd_en       <= 1'b0;
      bus.word_access <= 1'b1;
      bus.indirect    <= 1'b1;
      bus.from_internal_flash <= 1'b0;
      bus.addr        <= 4'h0;
      bus.wdata       <= RST_ZERO;
      cmd_ready       <= 1'b1;
      cmd_refused     <= 1'b0;
      rsp_valid       <= 1'b0;
      rsp_data        <= RST_ZERO;
      wait_r          <= 1'b0;
    end
    else
    begin
      bus.wr_en       <= take & cmd_write & ~refuse;
      bus.rd_en       <= take & ~cmd_write;
      bus.word_access <= 1'b1;
      bus.indirect    <= 1'b1;
      cmd_refused     <= take & refuse;
      rsp_valid       <= 1'b0;
      if (take)
      begin
        bus.addr        <= cmd_addr;
        bus.wdata       <= cmd_data;
        bus.from_internal_flash <= run_from_internal_flash;
        if (!cmd_write)
        begin
          cmd_ready <= 1'b0;
          wait_r    <= 1'b1;
        end
      end
      else if (wait_r && bus.rvalid)
      begin
        rsp_valid <= 1'b1;
        rsp_data  <= bus.rdata;
        cmd_ready <= 1'b1;
        wait_r    <= 1'b0;
      end
    end
  end
endmodule

// file: verif/fwos_bench.sv
`timescale 1ns/1ps
module fwos_bench
  import fwos_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        cmd_write = 1'b0;
  logic [3:0]  cmd_addr = 4'h0;
  logic [15:0] cmd_data = 16'h0000;
  logic        run_from_internal_flash = 1'b0;
  logic        cmd_ready, cmd_refused, rsp_valid, refused;
  logic        arr_wr_valid, arr_dword, arr_erase_valid, prot_access_on, prot_debug_on;
  logic [15:0] rsp_data, q;
  logic [23:0] arr_addr;
  logic [63:0] arr_data;
  logic [4:0]  arr_erase_sector, got_s;
  logic [88:0] got;
  int          errors = 0;
  int          compares = 0;
  int          n_prog = 0;
  int          n_erase = 0;
  int          k;
  fwos_if      link();
  fwos_if      link_b();
  fwos_host fwos_host_inst (.clk, .reset_n, .bus(link), .cmd_valid, .cmd_write, .cmd_addr, .cmd_data,
    .run_from_internal_flash, .cmd_ready, .cmd_refused, .rsp_valid, .rsp_data);
  fwos_device #(.PROG_CNT(12), .ERASE_CNT(20)) fwos_device_inst (.clk, .reset_n, .bus(link), .arr_wr_valid,
    .arr_addr, .arr_data, .arr_dword, .arr_erase_valid, .arr_erase_sector, .prot_access_on, .prot_debug_on);
  fwos_device #(.PROG_CNT(12), .ERASE_CNT(20)) fwos_device_inst_b (.clk, .reset_n, .bus(link_b),
    .arr_wr_valid(), .arr_addr(), .arr_data(), .arr_dword(), .arr_erase_valid(), .arr_erase_sector(),
    .prot_access_on(), .prot_debug_on());
  fwos_props fwos_props_inst (.clk, .reset_n, .wr_en(link.wr_en),
    .rd_en(link.rd_en), .word_access(link.word_access), .indirect(link.indirect), .from_internal_flash(link.from_internal_flash),
    .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid), .busy(link.busy));
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    if (arr_wr_valid === 1'b1)
    begin
      n_prog++;
      got = {arr_dword, arr_addr, arr_data};
    end
    if (arr_erase_valid === 1'b1)
    begin
      n_erase++;
      got_s = arr_erase_sector;
    end
  end
  task automatic chk(input logic [88:0] g, input logic [88:0] e);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    #1 cmd_valid = 1'b1;
    cmd_write = 1'b1;
    cmd_addr = a;
    cmd_data = d;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    #1 cmd_valid = 1'b0;
    refused = cmd_refused;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
    @(posedge clk);
    #1 cmd_valid = 1'b1;
    cmd_write = 1'b0;
    cmd_addr = a;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    #1 cmd_valid = 1'b0;
    for (int i = 0; i < 8 && rsp_valid !== 1'b1; i++) @(posedge clk) #1;
    chk(89'(rsp_data & m), 89'(e & m));
  endtask
  // second device driven raw, breaking the access form on purpose
  task automatic bw(input logic wa, input logic ind);
    @(posedge clk);
    #1 link_b.wr_en = 1'b1;
    link_b.wdata = 16'h1234;
    link_b.word_access = wa;
    link_b.indirect = ind;
    @(posedge clk);
    #1 link_b.wr_en = 1'b0;
    link_b.rd_en = 1'b1;
    @(posedge clk);
    #1 link_b.rd_en = 1'b0;
    q = link_b.rdata;
  endtask
  task automatic idle();
    repeat (3) @(posedge clk);
    #1;
    for (int i = 0; i < 200 && link.busy !== 1'b0; i++)
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic tick();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic close_out();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #300000;
    errors++;
    close_out();
  end
  initial
  begin
    link_b.wr_en = 1'b0;
    link_b.rd_en = 1'b0;
    link_b.word_access = 1'b1;
    link_b.indirect = 1'b1;
    link_b.from_internal_flash = 1'b0;
    link_b.addr = 4'h3;
    link_b.wdata = 16'h0000;
    repeat (5) @(posedge clk);
    #1 reset_n = 1'b1;
    bw(1'b1, 1'b0);
    chk(89'(q), 89'(0));
    bw(1'b0, 1'b1);
    chk(89'(q), 89'(0));
    bw(1'b1, 1'b1);
    chk(89'(q), 89'(16'h1234));
    $display("access form done");
    wr(4'h0, 16'h2000);
    wr(4'h3, 16'h5554);
    wr(4'h4, 16'h0002);
    wr(4'h5, 16'hAAAA);
    wr(4'h6, 16'hAAAA);
    wr(4'h0, 16'h8000);
    idle();
    chk(got, {1'b0, 24'h025554, 64'h0000_0000_AAAA_AAAA});
    rd(4'h0, 16'h0000);
    $display("word program done");
    wr(4'h0, 16'h1000);
    wr(4'h3, 16'h555C);
    wr(4'h4, 16'h0003);
    wr(4'h5, 16'h55AA);
    wr(4'h6, 16'h55AA);
    wr(4'h7, 16'hAA55);
    wr(4'h8, 16'hAA55);
    wr(4'h0, 16'h8000);
    idle();
    chk(got, {1'b1, 24'h035558, 64'hAA55_AA55_55AA_55AA});
    $display("double program done");
    k = n_prog;
    wr(4'h0, 16'h2000);
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h8000);
    idle();
    chk(89'(n_prog), 89'(k));
    $display("cancel done");
    wr(4'h0, 16'h0800);
    wr(4'h1, 16'h0003);
    wr(4'h0, 16'h8000);
    wr(4'h0, 16'h4000);
    rd(4'hC, 16'h0003);
    rd(4'h1, 16'h0003);
    wr(4'h0, 16'h8000);
    chk(89'(refused), 89'(1));
    // erase kept but a double program added: not a legal nested program
    wr(4'h0, 16'h1800);
    wr(4'h0, 16'h8000);
    rd(4'h9, 16'h0001);
    rd(4'hC, 16'h0000);
    $display("resume abort done");
    k = n_erase;
    wr(4'h0, 16'h0800);
    wr(4'h1, 16'h0002);
    wr(4'h0, 16'h8000);
    wr(4'h0, 16'h4000);
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h2000);
    wr(4'h3, 16'h5554);
    wr(4'h4, 16'h0004);
    wr(4'h5, 16'hAAAA);
    wr(4'h6, 16'h5555);
    wr(4'h0, 16'h8000);
    rd(4'h0, 16'h0000, 16'h4800);
    wr(4'h0, 16'h4000);
    tick();
    chk(89'(link.busy), 89'(1));
    idle();
    chk(got, {1'b0, 24'h045554, 64'h0000_0000_5555_AAAA});
    wr(4'h0, 16'h0800);
    wr(4'h0, 16'h8000);
    idle();
    rd(4'h1, 16'h0000);
    chk(89'(n_erase - k), 89'(1));
    chk(89'(got_s), 89'(1));
    $display("nested program done");
    wr(4'hA, 16'h0001);
    chk(89'(refused), 89'(1));
    wr(4'h0, 16'h0100);
    wr(4'h3, 16'hDFB8);
    wr(4'h4, 16'h0008);
    wr(4'h5, 16'hFFFC);
    wr(4'h0, 16'h8000);
    idle();
    chk(89'({prot_access_on, prot_debug_on}), 89'(2'b11));
    wr(4'h3, 16'h1111);
    rd(4'h3, 16'hDFB8);
    run_from_internal_flash = 1'b1;
    wr(4'hA, 16'h0001);
    wr(4'h3, 16'h0000);
    chk(89'(refused), 89'(1));
    tick();
    chk(89'(prot_access_on), 89'(0));
    run_from_internal_flash = 1'b0;
    wr(4'h0, 16'h0100);
    wr(4'h3, 16'hDFBC);
    wr(4'h5, 16'hFFFE);
    wr(4'h0, 16'h8000);
    idle();
    run_from_internal_flash = 1'b1;
    wr(4'hA, 16'h0000);
    run_from_internal_flash = 1'b0;
    tick();
    chk(89'(prot_access_on), 89'(0));
    wr(4'h0, 16'h0100);
    wr(4'h6, 16'hFFFE);
    wr(4'h0, 16'h8000);
    idle();
    tick();
    chk(89'(prot_access_on), 89'(1));
    $display("protection done");
    close_out();
  end
endmodule

// file: verif/fwos_props.sv
`timescale 1ns/1ps
module fwos_props
  import fwos_pkg::*;
#(
  parameter int PROG_CNT  = 12,
  parameter int ERASE_CNT = 20
)
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic        word_access,
  input wire logic        indirect,
  input wire logic        from_internal_flash,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        rvalid,
  input wire logic        busy
);
  logic        ctl_wr;
  logic        start_w;
  logic [15:0] sel_r;
  logic [15:0] sel_nxt;
  logic [1:0]  kind_r;
  logic [9:0]  run_r;
  assign ctl_wr  = wr_en && addr == OFS_CONTROL0_UPPER;
  assign start_w = ctl_wr && wdata[BIT_START];
  assign sel_nxt = (wdata & SELECT_MASK) | (start_w ? sel_r : 16'h0000);
  always_ff @(posedge clk)
    if (!reset_n)
      sel_r <= 16'h0000;
    else if (ctl_wr)
      sel_r <= sel_nxt;
  // a suspend voids the duration checks
  always_ff @(posedge clk)
    if (!reset_n)
      kind_r <= 2'h0;
    else if (ctl_wr && wdata[BIT_SUSPEND])
      kind_r <= 2'h0;
    else if (start_w)
      kind_r <= {sel_nxt[BIT_SER], |sel_nxt[BIT_WPG:BIT_DOUBLE_WORD_PROGRAM_SELECT]};
  always_ff @(posedge clk)
    if (!reset_n || !busy)
      run_r <= 10'h000;
    else
      run_r <= run_r + 10'h001;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_read;
    rd_en;
  endsequence
  sequence s_bare_start;
    start_w && sel_nxt == 16'h0000 && !busy;
  endsequence
  sequence s_erase_suspend_request;
    ctl_wr && wdata == 16'h4000 && busy && sel_r[BIT_SER];
  endsequence
  a_read_answer:
    assert property (s_read |=> rvalid)
    else $error("read not answered");
  a_answer_cause:
    assert property (rvalid |-> $past(rd_en))
    else $error("answer without read");
  a_word_indirect:
    assert property (wr_en |-> word_access && indirect)
    else $error("write not word indirect");
  a_busy_cause:
    assert property ($rose(busy) |-> $past(start_w) || $past(start_w, 2))
    else $error("busy without start");
  a_bare_start:
    assert property (s_bare_start |=> !busy [*4])
    else $error("start without select ran");
  a_prog_time:
    assert property ($fell(busy) && kind_r == 2'h1 |-> run_r >= PROG_CNT && run_r <= PROG_CNT + 2)
    else $error("program time off");
  a_erase_time:
    assert property ($fell(busy) && kind_r == 2'h2 |-> run_r >= ERASE_CNT)
    else $error("erase ended early");
  a_erase_suspend_request:
    assert property (s_erase_suspend_request |-> ##[1:3] !busy)
    else $error("erase not suspended");
endmodule
